// >>> rtl/nv_access_consts.svh
// constants for the nonvolatile data store and its access controller
`ifndef NV_ACCESS_CONSTS_SVH
`define NV_ACCESS_CONSTS_SVH

// store geometry
`define NV_DEPTH 512
`define NV_LAST_ADDR 9'h1ff

// register indices on the processor i/o port
`define NV_IDX_CONTROL 2'h0
`define NV_IDX_DATA 2'h1
`define NV_IDX_ADDR_LOW 2'h2
`define NV_IDX_ADDR_HIGH 2'h3

// control register bit positions
`define NV_BIT_READ_STROBE 0
`define NV_BIT_WRITE_STROBE 1
`define NV_BIT_MASTER_WE 2
`define NV_BIT_READY_IE 3

// control register reset value
`define NV_CONTROL_RESET 8'h00

// timing
`define NV_SYS_CLK_NS 10
`define NV_WRITE_TIME_NS 8500000
`define NV_WRITE_RC_CYCLES 67584
`define NV_RC_DIV (`NV_WRITE_TIME_NS / `NV_SYS_CLK_NS / `NV_WRITE_RC_CYCLES)
`define NV_READ_STALL 3'h4
`define NV_WRITE_STALL 3'h2
`define NV_MWE_WINDOW 3'h4

// host apb register map
`define NV_APB_CMD 8'h00
`define NV_APB_STATUS 8'h04
`define NV_CMD_DATA_LSB 0
`define NV_CMD_ADDR_LSB 8
`define NV_CMD_WRITE_BIT 24
`define NV_CMD_IRQ_EN_BIT 25
`define NV_STAT_BUSY_BIT 0
`define NV_STAT_LASTWR_BIT 1
`define NV_STAT_IRQ_BIT 2
`define NV_STAT_RDATA_LSB 8

`endif

// >>> rtl/nv_pkg.sv
// types shared by both ends of the nonvolatile access link, plus the core's sequencer states
package nv_pkg;
  typedef logic [8:0] nv_addr_t;
  typedef logic [7:0] nv_byte_t;
  typedef logic [1:0] nv_idx_t;
  typedef enum logic [3:0] {
    H_IDLE,
    H_POLL,
    H_CHECK,
    H_ADDR_HIGH,
    H_ADDR_LOW,
    H_DATA,
    H_ARM,
    H_STROBE,
    H_FETCH,
    H_TAKE
  } host_state_t;
endpackage

// >>> rtl/nv_link_if.sv
// processor i/o port between the core side and the nonvolatile access device
`timescale 1ns/10ps
interface nv_link_if;
  logic io_sel;
  logic io_write;
  nv_pkg::nv_idx_t io_addr;
  nv_pkg::nv_byte_t io_wdata;
  nv_pkg::nv_byte_t io_rdata;
  logic io_stall;
  logic ready_irq;
  logic global_int_enable;
  logic self_prog_busy;

  modport device (
    input io_sel,
    input io_write,
    input io_addr,
    input io_wdata,
    output io_rdata,
    output io_stall,
    output ready_irq,
    input global_int_enable,
    input self_prog_busy
  );

  modport core (
    output io_sel,
    output io_write,
    output io_addr,
    output io_wdata,
    input io_rdata,
    input io_stall,
    input ready_irq,
    output global_int_enable,
    output self_prog_busy
  );
endinterface

// >>> rtl/nv_access_device.sv
// nonvolatile data store with its address, data and control registers
`timescale 1ns/10ps
`include "nv_access_consts.svh"

module nv_access_device #(
  parameter int unsigned WRITE_RC_CYCLES = `NV_WRITE_RC_CYCLES,
  parameter int unsigned RC_DIV = `NV_RC_DIV
) (
  input wire logic sys_clk, // system clock, 100 MHz
  input wire logic sys_rst, // synchronous reset, active high
  nv_link_if.device link, // processor i/o port
  output logic write_busy // a write is being programmed
);
  import nv_pkg::*;

  nv_byte_t mem [0:`NV_DEPTH-1];
  nv_addr_t addr_reg;
  nv_byte_t data_reg;
  nv_addr_t wr_addr_reg;
  nv_byte_t wr_data_reg;
  logic ready_ie_reg;
  logic [2:0] mwe_cnt_reg;
  logic write_strobe_reg;
  logic read_strobe_reg;
  logic [2:0] stall_cnt_reg;
  logic [2:0] stall_cnt_next;
  logic stall_reg;
  logic [16:0] rc_cnt_reg;
  logic [7:0] div_reg;
  nv_byte_t rdata_reg;
  logic irq_reg;

  logic access;
  logic acc_wr;
  logic acc_rd;
  logic wr_ctrl;
  logic start_wr;
  logic start_rd;
  logic rc_tick;
  logic wr_done;

  // requests are taken only while the core is not held
  assign access = link.io_sel && (stall_cnt_reg == 3'h0);
  assign acc_wr = access && link.io_write;
  assign acc_rd = access && !link.io_write;
  assign wr_ctrl = acc_wr && (link.io_addr == `NV_IDX_CONTROL);

  // the enable window is read before this write can rearm it
  assign start_wr = wr_ctrl && link.io_wdata[`NV_BIT_WRITE_STROBE]
    && (mwe_cnt_reg != 3'h0)
    && !write_strobe_reg
    && !link.self_prog_busy;
  assign start_rd = wr_ctrl && link.io_wdata[`NV_BIT_READ_STROBE]
    && !write_strobe_reg;

  assign rc_tick = write_strobe_reg && (div_reg == 8'(RC_DIV - 1));
  assign wr_done = rc_tick && (rc_cnt_reg == 17'(WRITE_RC_CYCLES - 1));

  // oscillator tick derived from the system clock, runs only while writing
  always_ff @(posedge sys_clk) begin
    if (!write_strobe_reg || rc_tick) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  // write engine; busy is tested before reset so a reset cannot cut
  // a write short and leave a half-programmed byte
  always_ff @(posedge sys_clk) begin
    if (write_strobe_reg) begin
      if (wr_done) begin
        write_strobe_reg <= 1'b0;
        rc_cnt_reg <= 17'h00000;
      end else if (rc_tick) begin
        rc_cnt_reg <= rc_cnt_reg + 17'h00001;
      end
    end else if (sys_rst) begin
      write_strobe_reg <= 1'b0;
      rc_cnt_reg <= 17'h00000;
    end else if (start_wr) begin
      write_strobe_reg <= 1'b1;
      rc_cnt_reg <= 17'h00000;
      wr_addr_reg <= addr_reg;
      wr_data_reg <= data_reg;
    end
  end

  // storage array, one byte per location
  always_ff @(posedge sys_clk) begin
    if (wr_done) begin
      mem[wr_addr_reg] <= wr_data_reg;
    end
  end

  // address register: no reset, software must load it before use
  always_ff @(posedge sys_clk) begin
    if (acc_wr && !write_strobe_reg) begin
      if (link.io_addr == `NV_IDX_ADDR_HIGH) begin
        addr_reg[8] <= link.io_wdata[0];
      end else if (link.io_addr == `NV_IDX_ADDR_LOW) begin
        addr_reg[7:0] <= link.io_wdata;
      end
    end
  end

  // data register: loaded by software or by a read fetch
  always_ff @(posedge sys_clk) begin
    if (start_rd) begin
      data_reg <= mem[addr_reg];
    end else if (acc_wr && (link.io_addr == `NV_IDX_DATA)) begin
      data_reg <= link.io_wdata;
    end
  end

  // master write enable window counter
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mwe_cnt_reg <= 3'h0;
    end else if (wr_ctrl && link.io_wdata[`NV_BIT_MASTER_WE]
                 && !link.io_wdata[`NV_BIT_WRITE_STROBE]) begin
      mwe_cnt_reg <= `NV_MWE_WINDOW;
    end else if (mwe_cnt_reg != 3'h0) begin
      mwe_cnt_reg <= mwe_cnt_reg - 3'h1;
    end
  end

  // ready interrupt enable
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ready_ie_reg <= 1'b0;
    end else if (wr_ctrl) begin
      ready_ie_reg <= link.io_wdata[`NV_BIT_READY_IE];
    end
  end

  // read strobe reads back set until the core is released
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      read_strobe_reg <= 1'b0;
    end else if (start_rd) begin
      read_strobe_reg <= 1'b1;
    end else if (stall_cnt_reg == 3'h1) begin
      read_strobe_reg <= 1'b0;
    end
  end

  // processor hold after a read or a started write
  always_comb begin
    stall_cnt_next = stall_cnt_reg;
    if (start_rd) begin
      stall_cnt_next = `NV_READ_STALL;
    end else if (start_wr) begin
      stall_cnt_next = `NV_WRITE_STALL;
    end else if (stall_cnt_reg != 3'h0) begin
      stall_cnt_next = stall_cnt_reg - 3'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      stall_cnt_reg <= 3'h0;
      stall_reg <= 1'b0;
    end else begin
      stall_cnt_reg <= stall_cnt_next;
      stall_reg <= (stall_cnt_next != 3'h0);
    end
  end

  // register read-back, valid the cycle after the request
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdata_reg <= 8'h00;
    end else if (acc_rd) begin
      if (link.io_addr == `NV_IDX_CONTROL) begin
        rdata_reg <= {4'h0, ready_ie_reg, (mwe_cnt_reg != 3'h0),
                      write_strobe_reg, read_strobe_reg};
      end else if (link.io_addr == `NV_IDX_DATA) begin
        rdata_reg <= data_reg;
      end else if (link.io_addr == `NV_IDX_ADDR_LOW) begin
        rdata_reg <= addr_reg[7:0];
      end else begin
        rdata_reg <= {7'h00, addr_reg[8]};
      end
    end
  end

  // level request, not a flag: it drops as soon as a write starts
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= ready_ie_reg && link.global_int_enable
        && !write_strobe_reg && !start_wr;
    end
  end

  assign link.io_rdata = rdata_reg;
  assign link.io_stall = stall_reg;
  assign link.ready_irq = irq_reg;
  assign write_busy = write_strobe_reg;
endmodule

// >>> rtl/nv_access_core.sv
// core-side end: apb command registers driving the nonvolatile access sequence
`timescale 1ns/10ps
`include "nv_access_consts.svh"

module nv_access_core (
  input wire logic sys_clk, // system clock, 100 MHz
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high for write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic gie_in, // processor global interrupt enable
  input wire logic spm_busy_in, // flash self-programming in progress
  nv_link_if.core link // processor i/o port
);
  import nv_pkg::*;

  host_state_t state_reg;
  nv_addr_t cmd_addr_reg;
  nv_byte_t cmd_data_reg;
  logic cmd_write_reg;
  logic cmd_ie_reg;
  nv_byte_t rd_byte_reg;
  logic gap_reg;
  logic sel_reg;
  logic we_reg;
  nv_idx_t idx_reg;
  nv_byte_t wdata_reg;
  logic gie_reg;
  logic spm_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic setup;
  logic cmd_take;
  logic go;

  assign setup = psel && !penable && !pready_reg;
  // a write takes effect only at the completing edge
  assign cmd_take = psel && penable && pready_reg && pwrite
    && (paddr == `NV_APB_CMD) && (state_reg == H_IDLE);
  assign go = !gap_reg && !link.io_stall && !sel_reg;

  // apb slave: no wait state, answer prepared in the setup cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup && (paddr != `NV_APB_CMD) && (paddr != `NV_APB_STATUS);
      if (setup && !pwrite && (paddr == `NV_APB_CMD)) begin
        prdata_reg <= {6'h00, cmd_ie_reg, cmd_write_reg, 7'h00, cmd_addr_reg, cmd_data_reg};
      end else if (setup && !pwrite && (paddr == `NV_APB_STATUS)) begin
        prdata_reg <= {16'h0000, rd_byte_reg, 5'h00, link.ready_irq, cmd_write_reg,
                       (state_reg != H_IDLE)};
      end else if (setup) begin
        prdata_reg <= 32'h00000000;
      end
    end
  end

  // sequencer; each access is one select cycle then a gap so the
  // device's hold becomes visible before the next is issued
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg <= H_IDLE;
      sel_reg <= 1'b0;
      we_reg <= 1'b0;
      idx_reg <= `NV_IDX_CONTROL;
      wdata_reg <= 8'h00;
      gap_reg <= 1'b0;
      cmd_addr_reg <= 9'h000;
      cmd_data_reg <= 8'h00;
      cmd_write_reg <= 1'b0;
      cmd_ie_reg <= 1'b0;
      rd_byte_reg <= 8'h00;
    end else begin
      sel_reg <= 1'b0;
      gap_reg <= sel_reg;
      case (state_reg)
        H_IDLE: begin
          if (cmd_take) begin
            cmd_data_reg <= pwdata[`NV_CMD_DATA_LSB +: 8];
            cmd_addr_reg <= pwdata[`NV_CMD_ADDR_LSB +: 9];
            cmd_write_reg <= pwdata[`NV_CMD_WRITE_BIT];
            cmd_ie_reg <= pwdata[`NV_CMD_IRQ_EN_BIT];
            state_reg <= H_POLL;
          end
        end
        H_POLL: begin
          if (go) begin
            sel_reg <= 1'b1;
            we_reg <= 1'b0;
            idx_reg <= `NV_IDX_CONTROL;
            state_reg <= H_CHECK;
          end
        end
        H_CHECK: begin
          if (go) begin
            if (link.io_rdata[`NV_BIT_WRITE_STROBE] || spm_reg) begin
              state_reg <= H_POLL;
            end else begin
              state_reg <= H_ADDR_HIGH;
            end
          end
        end
        H_ADDR_HIGH: begin
          if (go) begin
            sel_reg <= 1'b1;
            we_reg <= 1'b1;
            idx_reg <= `NV_IDX_ADDR_HIGH;
            wdata_reg <= {7'h00, cmd_addr_reg[8]};
            state_reg <= H_ADDR_LOW;
          end
        end
        H_ADDR_LOW: begin
          if (go) begin
            sel_reg <= 1'b1;
            we_reg <= 1'b1;
            idx_reg <= `NV_IDX_ADDR_LOW;
            wdata_reg <= cmd_addr_reg[7:0];
            state_reg <= cmd_write_reg ? H_DATA : H_STROBE;
          end
        end
        H_DATA: begin
          if (go) begin
            sel_reg <= 1'b1;
            we_reg <= 1'b1;
            idx_reg <= `NV_IDX_DATA;
            wdata_reg <= cmd_data_reg;
            state_reg <= H_ARM;
          end
        end
        H_ARM: begin
          if (go) begin
            sel_reg <= 1'b1;
            we_reg <= 1'b1;
            idx_reg <= `NV_IDX_CONTROL;
            // interrupt enable rides on every control write, else it is lost
            wdata_reg <= {4'h0, cmd_ie_reg, 3'h4};
            state_reg <= H_STROBE;
          end
        end
        H_STROBE: begin
          if (go) begin
            sel_reg <= 1'b1;
            we_reg <= 1'b1;
            idx_reg <= `NV_IDX_CONTROL;
            // separate write, three cycles after arming, well inside the window
            wdata_reg <= {4'h0, cmd_ie_reg, (cmd_write_reg ? 3'h6 : 3'h1)};
            state_reg <= cmd_write_reg ? H_IDLE : H_FETCH;
          end
        end
        H_FETCH: begin
          if (go) begin
            sel_reg <= 1'b1;
            we_reg <= 1'b0;
            idx_reg <= `NV_IDX_DATA;
            state_reg <= H_TAKE;
          end
        end
        H_TAKE: begin
          if (go) begin
            rd_byte_reg <= link.io_rdata;
            state_reg <= H_IDLE;
          end
        end
        default: begin
          state_reg <= H_IDLE;
        end
      endcase
    end
  end

  // interrupts held off while a sequence runs
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      gie_reg <= 1'b0;
      spm_reg <= 1'b0;
    end else begin
      gie_reg <= gie_in && (state_reg == H_IDLE) && !cmd_take;
      spm_reg <= spm_busy_in;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign link.io_sel = sel_reg;
  assign link.io_write = we_reg;
  assign link.io_addr = idx_reg;
  assign link.io_wdata = wdata_reg;
  assign link.global_int_enable = gie_reg;
  assign link.self_prog_busy = spm_reg;
endmodule

// >>> sim/nv_link_monitor.sv
// concurrent checks on the processor i/o port between core and device
`timescale 1ns/10ps
`include "nv_access_consts.svh"
module nv_link_monitor #(
  parameter int unsigned WRITE_RC_CYCLES = 8,
  parameter int unsigned RC_DIV = 2
) (
  input wire logic sys_clk, // clock
  input wire logic sys_rst, // sync reset
  input wire logic io_sel, // request strobe
  input wire logic io_write, // direction
  input wire nv_pkg::nv_idx_t io_addr, // register index
  input wire nv_pkg::nv_byte_t io_wdata, // write byte
  input wire nv_pkg::nv_byte_t io_rdata, // read answer
  input wire logic io_stall, // core hold
  input wire logic ready_irq, // ready request
  input wire logic global_int_enable, // core enable
  input wire logic self_prog_busy, // flash busy
  input wire logic write_busy // programming
);
  import nv_pkg::*;
  localparam int unsigned WRITE_CYCLES = WRITE_RC_CYCLES * RC_DIV;
  logic ctrl_wr, arm_take, strobe_take, strobe_ok, rd_take, rd_any;
  logic [2:0] arm_age;
  logic ie_seen;
  int unsigned busy_len;

  assign ctrl_wr = io_sel & io_write & !io_stall & (io_addr == `NV_IDX_CONTROL);
  assign arm_take = ctrl_wr & io_wdata[`NV_BIT_MASTER_WE] & !io_wdata[`NV_BIT_WRITE_STROBE];
  assign strobe_take = ctrl_wr & io_wdata[`NV_BIT_WRITE_STROBE];
  assign strobe_ok = strobe_take & (arm_age != 3'h0) & (arm_age <= `NV_MWE_WINDOW)
    & !self_prog_busy & !write_busy;
  assign rd_take = ctrl_wr & io_wdata[`NV_BIT_READ_STROBE] & !write_busy;
  assign rd_any = io_sel & !io_write & !io_stall;

  // age of the master enable, 1 at the first edge after arming
  always_ff @(posedge sys_clk) begin
    if (sys_rst) arm_age <= 3'h0;
    else if (arm_take) arm_age <= 3'h1;
    else if (arm_age != 3'h0 && arm_age < 3'h7) arm_age <= arm_age + 3'h1;
  end

  // mirror of the ready interrupt enable, loaded by each accepted control write
  always_ff @(posedge sys_clk) begin
    if (sys_rst) ie_seen <= 1'b0;
    else if (ctrl_wr) ie_seen <= io_wdata[`NV_BIT_READY_IE];
  end

  // not cleared by reset: a running write outlives it
  always_ff @(posedge sys_clk) begin
    if (!write_busy) busy_len <= 0;
    else busy_len <= busy_len + 1;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_read_hold; io_stall [*4] ##1 !io_stall; endsequence
  sequence s_write_hold; io_stall [*2] ##1 !io_stall; endsequence

  property p_read_stall; rd_take |=> s_read_hold; endproperty
  a_read_stall: assert property (p_read_stall) else $error("read stall length wrong");
  property p_write_stall; strobe_ok |=> write_busy ##0 s_write_hold; endproperty
  a_write_stall: assert property (p_write_stall) else $error("write start wrong");
  property p_start_cause; $rose(write_busy) |-> $past(strobe_ok); endproperty
  a_start_cause: assert property (p_start_cause) else $error("write began uncaused");
  property p_busy_len; $fell(write_busy) |-> busy_len == WRITE_CYCLES; endproperty
  a_busy_len: assert property (p_busy_len) else $error("write time wrong");
  property p_busy_bound; write_busy |-> busy_len < WRITE_CYCLES; endproperty
  a_busy_bound: assert property (p_busy_bound) else $error("write overran");
  property p_irq_quiet;
    ($past(write_busy) || !$past(global_int_enable)) |-> !ready_irq;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("ready request while busy");
  property p_irq_level;
    (ie_seen && global_int_enable && !write_busy && !strobe_ok) |=> ready_irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("ready request missing");
  property p_arm_strobe; arm_take |-> ##[1:4] strobe_take; endproperty
  a_arm_strobe: assert property (p_arm_strobe) else $error("strobe missed window");
  property p_sel_gap; io_sel |-> !io_stall ##1 !io_sel; endproperty
  a_sel_gap: assert property (p_sel_gap) else $error("request during hold");
  property p_stall_cause; $rose(io_stall) |-> $past(rd_take || strobe_ok); endproperty
  a_stall_cause: assert property (p_stall_cause) else $error("hold uncaused");
  property p_rdata_hold; !$past(rd_any) |-> $stable(io_rdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_reset_clear;
    disable iff (1'b0) sys_rst |=> !io_stall && !ready_irq;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset left hold");
endmodule

// >>> sim/eeprom_data_access_controller_tb_top.sv
// table and directed tests of core and device joined over the i/o port
`timescale 1ns/10ps
`include "nv_access_consts.svh"
module eeprom_data_access_controller_tb_top;
  import nv_pkg::*;
  typedef struct {logic wr; nv_addr_t addr; nv_byte_t data;} row_t;
  logic sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, gie_in, spm_busy_in;
  logic write_busy, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int err_total, checked, n;
  row_t rows[8];

  nv_link_if link();
  nv_access_core nv_access_core_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .gie_in(gie_in), .spm_busy_in(spm_busy_in),
    .link(link));
  // short write time keeps the run brief
  nv_access_device #(.WRITE_RC_CYCLES(8), .RC_DIV(2)) nv_access_device_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .link(link), .write_busy(write_busy));
  nv_link_monitor #(.WRITE_RC_CYCLES(8), .RC_DIV(2)) nv_link_monitor_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .io_sel(link.io_sel), .io_write(link.io_write),
    .io_addr(link.io_addr), .io_wdata(link.io_wdata), .io_rdata(link.io_rdata),
    .io_stall(link.io_stall), .ready_irq(link.ready_irq),
    .global_int_enable(link.global_int_enable), .self_prog_busy(link.self_prog_busy),
    .write_busy(write_busy));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_flag(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // pready is read before this edge's updates land, so it is the sampled value
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // no local limit: only the watchdog ends a wait
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    do begin apb(1'b0, `NV_APB_STATUS, 32'h0); k++; end
      while (rd[`NV_STAT_BUSY_BIT] !== 1'b0 && k < 200);
    if (k >= 200) err_total++;
  endtask

  task automatic cmd(input logic wr, input nv_addr_t a, input nv_byte_t d);
    apb(1'b1, `NV_APB_CMD, {7'h0, wr, 7'h0, a, d});
    wait_idle();
  endtask

  initial begin
    sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; gie_in = 1'b1; spm_busy_in = 1'b0; err_total = 0; checked = 0;
    rows = '{'{1'b1, 9'h000, 8'ha5}, '{1'b1, 9'h1ff, 8'h3c}, '{1'b1, 9'h100, 8'h81},
      '{1'b0, 9'h1ff, 8'h3c}, '{1'b0, 9'h000, 8'ha5}, '{1'b1, 9'h0ff, 8'h7e},
      '{1'b0, 9'h0ff, 8'h7e}, '{1'b0, 9'h100, 8'h81}};
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    apb(1'b0, `NV_APB_STATUS, 32'h0);
    check_flag(rd[`NV_STAT_BUSY_BIT], 1'b0);
    check_flag(link.io_stall, 1'b0);
    check_flag(er, 1'b0);
    $display("test reset done");
    foreach (rows[i]) begin
      cmd(rows[i].wr, rows[i].addr, rows[i].data);
      check_flag(rd[`NV_STAT_LASTWR_BIT], rows[i].wr);
      if (!rows[i].wr) check_word({24'h0, rd[15:8]}, {24'h0, rows[i].data});
    end
    $display("test table done");
    // reset lands while the byte is being programmed
    apb(1'b1, `NV_APB_CMD, {7'h0, 1'b1, 7'h0, 9'h055, 8'hc3});
    n = 0;
    while (write_busy !== 1'b1 && n < 100) begin @(posedge sys_clk); n++; end
    sys_rst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    check_flag(write_busy, 1'b1);
    cmd(1'b0, 9'h055, 8'h00);
    check_word({24'h0, rd[15:8]}, 32'h0000_00c3);
    $display("test reset mid write done");
    // flash self-programming holds the write off
    spm_busy_in <= 1'b1;
    apb(1'b1, `NV_APB_CMD, {7'h0, 1'b1, 7'h0, 9'h1aa, 8'h5a});
    repeat (40) @(posedge sys_clk);
    check_flag(write_busy, 1'b0);
    spm_busy_in <= 1'b0;
    wait_idle();
    cmd(1'b0, 9'h1aa, 8'h00);
    check_word({24'h0, rd[15:8]}, 32'h0000_005a);
    apb(1'b0, `NV_APB_CMD, 32'h0);
    check_word(rd, {7'h0, 1'b0, 7'h0, 9'h1aa, 8'h00});
    $display("test self program lockout done");
    // ready request: low while programming, a level once idle with both enables
    apb(1'b1, `NV_APB_CMD, {6'h0, 1'b1, 1'b1, 7'h0, 9'h077, 8'h99});
    n = 0;
    while (write_busy !== 1'b1 && n < 100) begin @(posedge sys_clk); n++; end
    apb(1'b0, `NV_APB_STATUS, 32'h0);
    check_flag(rd[`NV_STAT_IRQ_BIT], 1'b0);
    while (write_busy !== 1'b0 && n < 200) begin @(posedge sys_clk); n++; end
    apb(1'b0, `NV_APB_STATUS, 32'h0);
    check_flag(rd[`NV_STAT_IRQ_BIT], 1'b1);
    gie_in <= 1'b0;
    repeat (3) @(posedge sys_clk);
    apb(1'b0, `NV_APB_STATUS, 32'h0);
    check_flag(rd[`NV_STAT_IRQ_BIT], 1'b0);
    gie_in <= 1'b1;
    $display("test ready request done");
    apb(1'b1, 8'h0c, 32'hffff_ffff);
    check_flag(er, 1'b1);
    apb(1'b0, 8'h08, 32'h0);
    check_flag(er, 1'b1);
    check_word(rd, 32'h0);
    $display("test unmapped done");
    complete_run();
  end

  // whole run needs well under a thousand cycles
  initial begin
    repeat (30000) @(posedge sys_clk);
    err_total++;
    complete_run();
  end
endmodule
